//--- verilog/cfm_params.svh
/*
 * constants of the converter fault manager: comparator bit map, time figures and
 * cycle counts derived from them.
 * assumes a single 250 MHz system clock.
 */
`ifndef CFM_PARAMS_SVH
`define CFM_PARAMS_SVH

// ****************************************
// clock
// ****************************************
`define CFM_CLK_MHZ 250

// ****************************************
// times in their own units and derived cycle counts
// ****************************************
`define CFM_OVFILT_NS 400
`define CFM_OVFILT_CYC ((`CFM_OVFILT_NS * `CFM_CLK_MHZ + 999) / 1000)
`define CFM_BODG_US 50000
`define CFM_BODG_CYC (`CFM_BODG_US * `CFM_CLK_MHZ)
`define CFM_XCDDET_US 20000
`define CFM_XCDDET_CYC (`CFM_XCDDET_US * `CFM_CLK_MHZ)
`define CFM_UVP_US 6600
`define CFM_UVP_CYC (`CFM_UVP_US * `CFM_CLK_MHZ)
`define CFM_CNT_W 24
`define CFM_RESTART_RISES 3'h6

// ****************************************
// comparator bit map
// ****************************************
`define CFM_NCMP 10
`define CFM_B_OVV 0
`define CFM_B_OVI 1
`define CFM_B_BI 2
`define CFM_B_BO 3
`define CFM_B_PK 4
`define CFM_B_OC2 5
`define CFM_B_THM 6
`define CFM_B_PVL 7
`define CFM_B_LINE 8
`define CFM_B_HVMIN 9

`endif

//--- verilog/cfm_pkg.sv
/*
 * types of the converter fault manager.
 * assumes nothing of its surroundings.
 */
package cfm_pkg;
	// main fault state
	typedef enum logic [2:0] {
		fs_wait_line,
		fs_run,
		fs_burst,
		fs_sec_hold,
		fs_auto,
		fs_cond_wait,
		fs_cond_cycle
	} cfm_state_t;
	// second level overcurrent tracker
	typedef enum logic {oc_idle, oc_warn} cfm_oc_t;
	// cause of a conditioned restart
	typedef enum logic [1:0] {cc_therm, cc_line_low, cc_discharge} cfm_cause_t;
endpackage

//--- verilog/cfm_cmp_if.sv
/*
 * carrier for the protection comparator levels, raw and synchronised.
 * assumes the synchroniser and the fault manager share one clock.
 */
`include "cfm_params.svh"
interface cfm_cmp_if;
	logic [`CFM_NCMP-1:0] raw;
	logic [`CFM_NCMP-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface

//--- verilog/cfm_sync.sv
/*
 * three flop synchroniser with agreement filter for each comparator level.
 * assumes raw levels are asynchronous to i_clk.
 */
`include "cfm_params.svh"
module cfm_sync (
	input wire logic i_clk,     // system clock
	input wire logic i_rst_b,   // synchronous reset, low active
	cfm_cmp_if.sync port        // comparator levels
);
	// ****************************************
	// per bit chain
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `CFM_NCMP; g++) begin : g_bit
			logic s1, s2, s3, lvl;
			logic next_s1, next_s2, next_s3, next_lvl;
			// a change counts once second and third stage agree
			always_comb begin
				next_s1 = port.raw[g];
				next_s2 = s1;
				next_s3 = s2;
				next_lvl = (s2 == s3) ? s3 : lvl;
			end
			// registers of the chain
			always_ff @(posedge i_clk) begin
				if (!i_rst_b) begin
					s1 <= 1'h0;
					s2 <= 1'h0;
					s3 <= 1'h0;
					lvl <= 1'h0;
				end else begin
					s1 <= next_s1;
					s2 <= next_s2;
					s3 <= next_s3;
					lvl <= next_lvl;
				end
			end
			assign port.clean[g] = lvl;
		end
	endgenerate
endmodule

//--- verilog/cfm_fault_mgr.sv
/*
 * converter fault manager: soft-start overvoltage filter, brown-in and brown-out,
 * peak clamp and second level overcurrent, thermistor, supply lockout, x-cap
 * discharge and restart policies for primary and secondary faults.
 * assumes comparator pins are asynchronous and all timing strobes and secondary
 * fault levels come from logic on i_clk.
 */
// Notes on behaviour
// [R1]: overvoltage detection armed only in soft-start, off once secondary controls.
// [R2]: overvoltage sense evaluated only during high-side on-time.
// [R3]: flyback and forward detectors both armed; either raises the fault.
// [R4]: fault only after detector asserted longer than filter time.
// [R5]: flyback detector is the voltage threshold comparator.
// [R6]: forward detector is the clamp current threshold comparator.
// [R7]: no conversion until line rises above brown-in level.
// [R8]: line below brown-out beyond mask time stops until brown-in again.
// [R9]: after blanking, peak clamp drops low-side gate; operation continues.
// [R10]: second level trip warns; clean next cycle idles, second trip stops.
// [R11]: confirmed second level overcurrent uses auto-restart.
// [R12]: thermistor low stops conversion under conditioned restart.
// [R13]: primary supply below off level enters auto-restart.
// [R14]: primary overvoltage stops switching into burst; no secondary means lockout. Here burst ends in auto-restart once the primary supply falls.
// [R15]: soft-start end without secondary signal is an auto-restart fault.
// [R16]: brown-out and discharge use conditioned restart and clear other faults.
// [R17]: secondary overcurrent opens load switch, else primary overcurrent covers.
// [R18]: secondary overvoltage holds until output back in safe range.
// [R19]: secondary undervoltage lasting 6.6 ms stops until primary restart.
// [R20]: secondary supply lockout stops until primary restart.
// [R21]: secondary overtemperature keeps switching, opens load switch, sends hard reset.
// [R22]: after disconnect wait discharge delay, discharge until line minimum or reconnect.
// [R23]: auto-restart waits six supply fall-and-rise cycles.
// [R24]: conditioned restart waits for clear, then one supply cycle.
// [R25]: comparator outputs synchronised before any use.
`include "cfm_params.svh"
module cfm_fault_mgr #(
	parameter logic [`CFM_CNT_W-1:0] BODG_CYC = `CFM_CNT_W'(`CFM_BODG_CYC),
	parameter logic [`CFM_CNT_W-1:0] XCDDET_CYC = `CFM_CNT_W'(`CFM_XCDDET_CYC),
	parameter logic [`CFM_CNT_W-1:0] UVP_CYC = `CFM_CNT_W'(`CFM_UVP_CYC)
) (
	input wire logic i_clk,                  // system clock, 250 MHz
	input wire logic i_rst_b,                // synchronous reset, low active
	input wire logic i_ov_volt_cmp,          // aux sense above voltage threshold
	input wire logic i_ov_curr_cmp,          // aux clamp current above threshold
	input wire logic i_line_above_bi,        // line sense above brown-in peak
	input wire logic i_line_below_bo,        // line sense below brown-out level
	input wire logic i_peak_clamp_cmp,       // current sense above peak clamp level
	input wire logic i_second_level_cmp,     // current sense above second level
	input wire logic i_thermistor_low,       // thermistor sense below threshold
	input wire logic i_supply_low,           // primary supply rail below off level
	input wire logic i_line_present,         // mains connection detected
	input wire logic i_line_below_min,       // line sense pin below minimum
	input wire logic i_hs_on,                // high-side switch on-time
	input wire logic i_cycle_start,          // pulse at each switching cycle start
	input wire logic i_leb_done,             // blanking time elapsed in this cycle
	input wire logic i_gate_demand,          // low-side gate request from loop
	input wire logic i_soft_start,           // primary soft-start in progress
	input wire logic i_sec_in_control,       // secondary drives conversion
	input wire logic i_ss_end,               // soft-start ramp at end level
	input wire logic i_sec_signal,           // signalling seen from secondary
	input wire logic i_sec_ocp,              // secondary overcurrent
	input wire logic i_load_switch_fitted,   // load switch present
	input wire logic i_sec_ovp,              // secondary overvoltage
	input wire logic i_sec_out_safe,         // output back in safe range
	input wire logic i_sec_uvp,              // secondary output undervoltage
	input wire logic i_sec_uvlo,             // secondary supply lockout
	input wire logic i_sec_otp,              // secondary overtemperature
	output logic o_low_side_gate_on,         // low-side gate, registered
	output logic o_switch_en,                // switching allowed, registered
	output logic o_burst,                    // burst after primary overvoltage
	output logic o_load_switch_open,         // open the load switch, registered
	output logic o_hard_reset,               // one cycle hard reset request
	output logic o_discharge_en,             // discharge through line sense pin
	output logic o_ocp_warning,              // second level warning state
	output cfm_pkg::cfm_state_t o_state      // fault state, registered
);
	import cfm_pkg::*;

	// ****************************************
	// comparator synchronisation
	// ****************************************
	cfm_cmp_if cmp ();
	logic ovv, ovi, bi, bo, pk, oc2, thm, pvl, line, hvmin;
	// raw levels in, clean levels out, msb first in the order of the bit map
	assign cmp.raw = {i_line_below_min, i_line_present, i_supply_low, i_thermistor_low,
		i_second_level_cmp, i_peak_clamp_cmp, i_line_below_bo, i_line_above_bi,
		i_ov_curr_cmp, i_ov_volt_cmp};
	assign {hvmin, line, pvl, thm, oc2, pk, bo, bi, ovi, ovv} = cmp.clean;
	// every comparator passes four flops before use, three synchroniser stages and the filter flop [R25]
	cfm_sync u_sync (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.port(cmp.sync)
	);
	// ****************************************
	// timers: overvoltage filter, brown-out mask, undervoltage, discharge
	// ****************************************
	cfm_state_t state, next_state;
	logic [`CFM_CNT_W-1:0] ov_cnt, bo_cnt, uvp_cnt, xcd_cnt;
	logic [`CFM_CNT_W-1:0] next_ov_cnt, next_bo_cnt, next_uvp_cnt, next_xcd_cnt;
	logic dis_on, dis_done, next_dis_on, next_dis_done;
	logic ov_armed, ov_det, ov_fault, bo_fault, uvp_fault, xcd_start;
	localparam logic [`CFM_CNT_W-1:0] OVF_CYC = `CFM_CNT_W'(`CFM_OVFILT_CYC);
	// detector gating and filter comparisons
	always_comb begin
		ov_armed = i_soft_start && !i_sec_in_control;           // [R1]
		ov_det = ov_armed && i_hs_on && (ovv || ovi);           // [R2] [R3] [R5] [R6]
		ov_fault = ov_det && (ov_cnt >= OVF_CYC);               // [R4]
		bo_fault = bo && (state != fs_wait_line) && (bo_cnt >= BODG_CYC); // [R8]
		uvp_fault = i_sec_uvp && (uvp_cnt >= UVP_CYC);          // [R19]
		xcd_start = !line && !dis_on && !dis_done && (xcd_cnt >= XCDDET_CYC); // [R22]
	end
	// next values of the timers
	always_comb begin
		next_ov_cnt = (ov_det && !ov_fault) ? ov_cnt + 1'b1 : '0;
		next_bo_cnt = (bo && state != fs_wait_line && !bo_fault) ? bo_cnt + 1'b1 : '0;
		next_uvp_cnt = (i_sec_uvp && !uvp_fault) ? uvp_cnt + 1'b1 : '0;
		next_dis_on = dis_on;
		next_dis_done = dis_done;
		next_xcd_cnt = xcd_cnt;
		if (line) begin
			// reconnection ends discharge and rearms the delay [R22]
			next_dis_on = 1'b0;
			next_dis_done = 1'b0;
			next_xcd_cnt = '0;
		end else if (dis_on) begin
			if (hvmin) begin
				next_dis_on = 1'b0;
				next_dis_done = 1'b1;
			end
		end else if (xcd_start) begin
			next_dis_on = !hvmin;
			next_dis_done = hvmin;
		end else if (!dis_done) begin
			next_xcd_cnt = xcd_cnt + 1'b1;
		end
	end
	// timer registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			ov_cnt <= '0;
			bo_cnt <= '0;
			uvp_cnt <= '0;
			xcd_cnt <= '0;
			dis_on <= 1'b0;
			dis_done <= 1'b0;
		end else begin
			ov_cnt <= next_ov_cnt;
			bo_cnt <= next_bo_cnt;
			uvp_cnt <= next_uvp_cnt;
			xcd_cnt <= next_xcd_cnt;
			dis_on <= next_dis_on;
			dis_done <= next_dis_done;
		end
	end

	// ****************************************
	// overcurrent: peak clamp cut and second level tracker
	// ****************************************
	cfm_oc_t oc_state, next_oc_state;
	logic oc_in_next, next_oc_in_next, oc_fault;
	logic cut, next_cut, next_gate;
	// gate cut after blanking, released at cycle start; no fault raised [R9]
	always_comb begin
		next_cut = cut;
		if (i_cycle_start) begin
			next_cut = 1'b0;
		end else if (i_leb_done && pk) begin
			next_cut = 1'b1;
		end
		next_gate = i_gate_demand && (next_state == fs_run) && !next_cut;
	end
	// warning, clean cycle back to idle, second trip confirms [R10]
	always_comb begin
		next_oc_state = oc_state;
		next_oc_in_next = oc_in_next;
		oc_fault = 1'b0;
		case (oc_state)
			oc_idle: begin
				next_oc_in_next = 1'b0;
				if (oc2 && state == fs_run) begin
					next_oc_state = oc_warn;
				end
			end
			oc_warn: begin
				if (oc_in_next && oc2) begin
					oc_fault = 1'b1;
					next_oc_state = oc_idle;
				end else if (i_cycle_start && oc_in_next) begin
					next_oc_state = oc_idle;
				end else if (i_cycle_start) begin
					next_oc_in_next = 1'b1;
				end
			end
			default: next_oc_state = oc_idle;
		endcase
		if (state != fs_run) begin
			next_oc_state = oc_idle;
		end
	end
	// overcurrent registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			oc_state <= oc_idle;
			oc_in_next <= 1'b0;
			cut <= 1'b0;
			o_low_side_gate_on <= 1'b0;
		end else begin
			oc_state <= next_oc_state;
			oc_in_next <= next_oc_in_next;
			cut <= next_cut;
			o_low_side_gate_on <= next_gate;
		end
	end
	assign o_ocp_warning = (oc_state == oc_warn);

	// ****************************************
	// fault state and restart policies
	// ****************************************
	cfm_cause_t cause, next_cause;
	logic [2:0] rises, next_rises;
	logic fell, next_fell, pvl_q, pvl_rise, cond_clear, auto_fault;
	logic otp_q, next_ls_open, next_hr;
	// supply rail back above off level after a fall
	assign pvl_rise = pvl_q && !pvl;
	// event selection and condition clearing
	always_comb begin
		auto_fault = oc_fault || pvl || uvp_fault || i_sec_uvlo   // [R11] [R13] [R19] [R20]
			|| (i_ss_end && !i_sec_signal);                        // [R15]
		case (cause)
			cc_therm: cond_clear = !thm;
			cc_line_low: cond_clear = bi;
			default: cond_clear = line;
		endcase
	end
	// state transitions
	always_comb begin
		next_state = state;
		next_cause = cause;
		next_rises = rises;
		next_fell = fell;
		if (bo_fault || xcd_start) begin
			// overrides every pending fault [R16]
			next_state = fs_cond_wait;
			next_cause = bo_fault ? cc_line_low : cc_discharge;
			next_rises = 3'h0;
		end else begin
			case (state)
				fs_wait_line: begin
					if (bi && !pvl) begin
						next_state = fs_run;                      // [R7]
					end
				end
				fs_run: begin
					if (ov_fault) begin
						next_state = fs_burst;                    // [R14]
					end else if (auto_fault) begin
						next_state = fs_auto;
						next_rises = 3'h0;
					end else if (thm) begin
						next_state = fs_cond_wait;                // [R12]
						next_cause = cc_therm;
					end else if (i_sec_ovp) begin
						next_state = fs_sec_hold;                 // [R18]
					end
				end
				fs_burst: begin
					if (pvl) begin
						next_state = fs_auto;                     // [R14]
						next_rises = 3'h0;
					end
				end
				fs_sec_hold: begin
					if (pvl) begin
						next_state = fs_auto;
						next_rises = 3'h0;
					end else if (i_sec_out_safe && !i_sec_ovp) begin
						next_state = fs_run;                      // [R18]
					end
				end
				fs_auto: begin
					if (pvl_rise) begin
						next_rises = rises + 3'h1;
						if (rises + 3'h1 == `CFM_RESTART_RISES) begin
							next_state = fs_wait_line;            // [R23]
						end
					end
				end
				fs_cond_wait: begin
					next_fell = 1'b0;
					if (cond_clear) begin
						next_state = fs_cond_cycle;               // [R24]
					end
				end
				fs_cond_cycle: begin
					if (!cond_clear) begin
						next_state = fs_cond_wait;
					end else if (fell && pvl_rise) begin
						next_state = fs_wait_line;                // [R24]
					end else if (pvl) begin
						next_fell = 1'b1;
					end
				end
				default: next_state = fs_wait_line;
			endcase
		end
		next_ls_open = (i_sec_ocp && i_load_switch_fitted) || i_sec_otp; // [R17] [R21]
		next_hr = i_sec_otp && !otp_q;                            // [R21]
	end
	// fault state registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_b) begin
			state <= fs_wait_line;
			cause <= cc_therm;
			rises <= 3'h0;
			fell <= 1'b0;
			pvl_q <= 1'b0;
			otp_q <= 1'b0;
			o_switch_en <= 1'b0;
			o_burst <= 1'b0;
			o_load_switch_open <= 1'b0;
			o_hard_reset <= 1'b0;
		end else begin
			state <= next_state;
			cause <= next_cause;
			rises <= next_rises;
			fell <= next_fell;
			pvl_q <= pvl;
			otp_q <= i_sec_otp;
			o_switch_en <= (next_state == fs_run);
			o_burst <= (next_state == fs_burst);
			o_load_switch_open <= next_ls_open;
			o_hard_reset <= next_hr;
		end
	end
	assign o_discharge_en = dis_on;
	assign o_state = state;

	// ****************************************
	// checks
	// ****************************************
	localparam int OVF_INT = `CFM_OVFILT_CYC;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	chk_ov_armed_window: assert property ((ov_cnt != '0) |-> $past(ov_armed)) // [R1]
		else $error("overvoltage filter ran while unarmed");
	chk_ov_on_time: assert property (!i_hs_on |=> ov_cnt == '0) // [R2]
		else $error("overvoltage filter ran outside on-time");
	chk_ov_filter_len: assert property ($rose(state == fs_burst) |-> $past(ov_cnt) >= OVF_INT) // [R4]
		else $error("overvoltage fault before filter time");
	chk_brown_in_gate: assert property ((state == fs_wait_line && !bi) |=> state != fs_run) // [R7]
		else $error("conversion started below brown-in");
	chk_peak_cut: assert property ((cut && !i_cycle_start) |=> !o_low_side_gate_on) // [R9]
		else $error("gate on after peak clamp cut");
	chk_oc_confirm: assert property ((state == fs_run && oc_fault && !bo_fault && !xcd_start
		&& !ov_fault) |=> state == fs_auto ##1 !o_switch_en) // [R10]
		else $error("confirmed overcurrent did not auto-restart");
	chk_line_low_clear: assert property (bo_fault |=> state == fs_cond_wait && rises == 3'h0) // [R16]
		else $error("brown-out did not clear pending faults");
	chk_auto_six: assert property ((state == fs_auto) ##1 (state == fs_wait_line)
		|-> $past(rises) == 3'h5) // [R23]
		else $error("auto-restart left before six supply cycles");
	chk_hard_reset: assert property ($rose(i_sec_otp) |=> o_hard_reset && o_load_switch_open) // [R21]
		else $error("overtemperature did not request hard reset");
	chk_discharge_line: assert property (line |=> !o_discharge_en) // [R22]
		else $error("discharge went on after mains returned");
	cov_ov_burst: cover property (state == fs_run ##1 state == fs_burst);
	cov_oc_recover: cover property (oc_state == oc_warn ##[1:300] oc_state == oc_idle
		&& state == fs_run);
	cov_auto_done: cover property (state == fs_auto ##1 state == fs_wait_line);
	cov_discharge: cover property ($rose(o_discharge_en));
endmodule

//--- bench/cfm_stage_model.sv
/*
 * power stage timing model: switching cycle start pulse, high-side on-time, blanking.
 * assumes one clock shared with the fault manager; outputs move 1 ns after each edge.
 */
module cfm_stage_model #(
	parameter int PERIOD = 256,
	parameter int ON = 150,
	parameter int LEB = 8
) (
	input wire logic i_clk,        // system clock
	input wire logic i_run,        // switching active
	input wire logic i_long_on,    // stretch on-time across cycles
	output logic o_cycle_start,    // one cycle pulse per switching cycle
	output logic o_hs_on,          // high-side on-time
	output logic o_leb_done        // blanking over
);
	timeunit 1ns;
	timeprecision 100ps;
	int phase;
	// idle stage at time zero
	initial begin
		phase = 0;
		o_cycle_start = 0;
		o_hs_on = 0;
		o_leb_done = 0;
	end
	// cycle phase, all outputs quiet while stopped
	always @(posedge i_clk) begin
		#1;
		phase = (!i_run || phase == PERIOD - 1) ? 0 : phase + 1;
		o_cycle_start = i_run && phase == 0;
		o_hs_on = i_run && (i_long_on || phase < ON);
		o_leb_done = i_run && phase >= LEB;
	end
endmodule

//--- bench/cfm_fault_mgr_bench.sv
/*
 * self-checking bench of the fault manager, scenario tasks and verdict.
 * assumes shortened counts: mask 50, discharge delay 40, undervoltage 60 cycles.
 */
module cfm_fault_mgr_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import cfm_pkg::*;
	logic clk, rst_b, ovv, ovi, bi, bo, pk, oc2, thm, sup_low, line, hvmin, gate, ss;
	logic sec_ctl, ss_end, sec_sig, s_ocp, ls_fit, s_ovp, s_safe, s_uvp, s_uvlo, s_otp;
	logic mrun, long_on, hs_on, cyc, leb;
	logic gate_on, sw_en, burst, ls_open, hreset, dis_en, warn;
	cfm_state_t st;
	int num_errors, n_compared;
	cfm_fault_mgr #(.BODG_CYC(24'h000032), .XCDDET_CYC(24'h000028), .UVP_CYC(24'h00003C))
	cfm_fault_mgr_i (.i_clk(clk), .i_rst_b(rst_b), .i_ov_volt_cmp(ovv), .i_ov_curr_cmp(ovi),
		.i_line_above_bi(bi), .i_line_below_bo(bo), .i_peak_clamp_cmp(pk),
		.i_second_level_cmp(oc2), .i_thermistor_low(thm), .i_supply_low(sup_low),
		.i_line_present(line), .i_line_below_min(hvmin), .i_hs_on(hs_on),
		.i_cycle_start(cyc), .i_leb_done(leb), .i_gate_demand(gate), .i_soft_start(ss),
		.i_sec_in_control(sec_ctl), .i_ss_end(ss_end), .i_sec_signal(sec_sig),
		.i_sec_ocp(s_ocp), .i_load_switch_fitted(ls_fit), .i_sec_ovp(s_ovp),
		.i_sec_out_safe(s_safe), .i_sec_uvp(s_uvp), .i_sec_uvlo(s_uvlo), .i_sec_otp(s_otp),
		.o_low_side_gate_on(gate_on), .o_switch_en(sw_en), .o_burst(burst),
		.o_load_switch_open(ls_open), .o_hard_reset(hreset), .o_discharge_en(dis_en),
		.o_ocp_warning(warn), .o_state(st));
	cfm_stage_model cfm_stage_model_i (.i_clk(clk), .i_run(mrun), .i_long_on(long_on),
		.o_cycle_start(cyc), .o_hs_on(hs_on), .o_leb_done(leb));
	// ****************************************
	// helpers
	// ****************************************
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk_bit(input string name, input logic exp, input logic got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %b seen %b", name, exp, got);
		end
	endtask
	task chk_state(input cfm_state_t exp);
		n_compared++;
		if (st !== exp) begin
			num_errors++;
			$display("FAIL state expected %0d seen %0d", exp, st);
		end
	endtask
	task wait_state(input cfm_state_t exp);
		int k;
		k = 0;
		while (st !== exp && k < 64) begin
			tick(1);
			k++;
		end
		chk_state(exp);
	endtask
	task supply_cycle;
		sup_low = 1;
		tick(8);
		sup_low = 0;
		tick(8);
	endtask
	task restart6;
		for (int k = 0; k < 6; k++) begin
			supply_cycle();
			if (k == 4) chk_state(fs_auto);
		end
		wait_state(fs_run);
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_reset_brownin;
		chk_state(fs_wait_line);
		chk_bit("switch_en", 0, sw_en);
		chk_bit("hard_reset", 0, hreset);
		tick(20);
		chk_bit("gate_on", 0, gate_on);
		chk_state(fs_wait_line);
		bi = 1;
		wait_state(fs_run);
		tick(2);
		chk_bit("switch_en", 1, sw_en);
		$display("test reset_brownin done");
	endtask
	task t_overvoltage;
		ovv = 1;
		tick(150);
		chk_state(fs_run);
		mrun = 1;
		long_on = 1;
		sec_ctl = 1;
		tick(150);
		chk_state(fs_run);
		{sec_ctl, ss} = 2'h0;
		tick(150);
		chk_state(fs_run);
		{ss, ovv} = 2'h2;
		tick(8);
		ovv = 1;
		tick(60);
		chk_state(fs_run);
		ovv = 0;
		tick(8);
		for (int d = 0; d < 2; d++) begin
			long_on = 1;
			if (d == 0) ovv = 1;
			else ovi = 1;
			tick(96);
			chk_state(fs_run);
			tick(20);
			chk_state(fs_burst);
			chk_bit("burst", 1, burst);
			chk_bit("switch_en", 0, sw_en);
			ovv = 0;
			ovi = 0;
			long_on = 0;
			sup_low = 1;
			wait_state(fs_auto);
			restart6();
		end
		$display("test overvoltage done");
	endtask
	task t_overcurrent;
		@(posedge cyc);
		tick(20);
		chk_bit("gate_on", 1, gate_on);
		pk = 1;
		tick(8);
		chk_bit("gate_on", 0, gate_on);
		chk_state(fs_run);
		pk = 0;
		@(posedge cyc);
		tick(3);
		chk_bit("gate_on", 1, gate_on);
		tick(20);
		oc2 = 1;
		tick(6);
		oc2 = 0;
		tick(2);
		chk_bit("warning", 1, warn);
		@(posedge cyc);
		@(posedge cyc);
		tick(3);
		chk_bit("warning", 0, warn);
		chk_state(fs_run);
		tick(20);
		oc2 = 1;
		tick(6);
		oc2 = 0;
		@(posedge cyc);
		tick(20);
		oc2 = 1;
		tick(6);
		oc2 = 0;
		wait_state(fs_auto);
		tick(2);
		chk_bit("switch_en", 0, sw_en);
		restart6();
		$display("test overcurrent done");
	endtask
	task t_thermistor;
		thm = 1;
		wait_state(fs_cond_wait);
		tick(2);
		chk_bit("switch_en", 0, sw_en);
		supply_cycle();
		chk_state(fs_cond_wait);
		thm = 0;
		wait_state(fs_cond_cycle);
		supply_cycle();
		wait_state(fs_run);
		$display("test thermistor done");
	endtask
	task t_brownout;
		bo = 1;
		bi = 0;
		tick(40);
		chk_state(fs_run);
		tick(30);
		chk_state(fs_cond_wait);
		bo = 0;
		tick(20);
		chk_state(fs_cond_wait);
		bi = 1;
		wait_state(fs_cond_cycle);
		supply_cycle();
		wait_state(fs_run);
		$display("test brownout done");
	endtask
	task t_secondary;
		s_otp = 1;
		tick(1);
		chk_bit("hard_reset", 1, hreset);
		tick(1);
		chk_bit("hard_reset", 0, hreset);
		chk_bit("load_open", 1, ls_open);
		chk_bit("switch_en", 1, sw_en);
		s_otp = 0;
		s_ocp = 1;
		ls_fit = 1;
		tick(3);
		chk_bit("load_open", 1, ls_open);
		ls_fit = 0;
		tick(3);
		chk_bit("load_open", 0, ls_open);
		s_ocp = 0;
		s_ovp = 1;
		wait_state(fs_sec_hold);
		s_ovp = 0;
		tick(10);
		chk_state(fs_sec_hold);
		s_safe = 1;
		wait_state(fs_run);
		s_safe = 0;
		$display("test secondary done");
	endtask
	task t_discharge;
		line = 0;
		tick(30);
		chk_bit("discharge", 0, dis_en);
		tick(30);
		chk_bit("discharge", 1, dis_en);
		chk_state(fs_cond_wait);
		hvmin = 1;
		tick(8);
		chk_bit("discharge", 0, dis_en);
		hvmin = 0;
		line = 1;
		wait_state(fs_cond_cycle);
		supply_cycle();
		wait_state(fs_run);
		line = 0;
		tick(60);
		chk_bit("discharge", 1, dis_en);
		line = 1;
		tick(8);
		chk_bit("discharge", 0, dis_en);
		supply_cycle();
		wait_state(fs_run);
		$display("test discharge done");
	endtask
	task t_auto_causes;
		for (int c = 0; c < 4; c++) begin
			case (c)
				0: sup_low = 1;
				1: {ss_end, sec_sig} = 2'h2;
				2: s_uvlo = 1;
				default: s_uvp = 1;
			endcase
			if (c == 3) begin
				tick(40);
				chk_state(fs_run);
			end
			wait_state(fs_auto);
			{ss_end, sec_sig, s_uvlo, s_uvp} = 4'h4;
			restart6();
		end
		$display("test auto_causes done");
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// ****************************************
	// clock, watchdog, main sequence
	// ****************************************
	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	initial begin
		#80000;
		num_errors++;
		tally_and_finish();
	end
	initial begin
		{ovv, ovi, bi, bo, pk, oc2, thm, sup_low, hvmin, sec_ctl, ss_end} = '0;
		{s_ocp, ls_fit, s_ovp, s_safe, s_uvp, s_uvlo, s_otp, mrun, long_on} = '0;
		{line, gate, ss, sec_sig} = 4'hF;
		num_errors = 0;
		n_compared = 0;
		rst_b = 0;
		tick(20);
		rst_b = 1;
		tick(1);
		t_reset_brownin();
		t_overvoltage();
		t_overcurrent();
		t_thermistor();
		t_brownout();
		t_secondary();
		t_discharge();
		t_auto_causes();
		tally_and_finish();
	end
endmodule
